//--- design/plm_pkg.sv
package plm_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [11:0] IDX_LOOP_CONTROL = 12'h010;
	localparam logic [11:0] IDX_REF_DIVIDER_LOW = 12'h011;
	localparam logic [11:0] IDX_REF_DIVIDER_HIGH = 12'h012;
	localparam logic [11:0] IDX_DETECTOR_PULSE_CONTROL = 12'h017;
	localparam logic [11:0] IDX_SYNC_CONTROL = 12'h019;
	localparam logic [11:0] IDX_MONITOR_PIN_SELECT = 12'h01b;
	localparam logic [11:0] IDX_REFERENCE_CONTROL = 12'h01c;
	localparam logic [11:0] IDX_PUMP_CURRENT = 12'h020;
	localparam logic [11:0] IDX_DIVIDER_RESET = 12'h021;
	localparam logic [11:0] IDX_SWITCH_OPTIONS = 12'h022;
	localparam logic [11:0] IDX_STATUS = 12'h023;
	localparam logic [11:0] IDX_UPDATE = 12'h232;

	// Field positions.
	localparam int LOOP_POLARITY_BIT = 7;
	localparam int LOOP_PUMP_MODE_LSB = 4;
	localparam int LOOP_POWER_LSB = 0;
	localparam int SYNC_ENABLE_LSB = 6;
	localparam int REFC_DIFF_BIT = 0;
	localparam int REFC_PRIMARY_ON_BIT = 1;
	localparam int REFC_SECONDARY_ON_BIT = 2;
	localparam int REFC_PIN_SELECT_BIT = 3;
	localparam int REFC_MANUAL_SECONDARY_BIT = 4;
	localparam int REFC_AUTO_BIT = 5;
	localparam int REFC_SECONDARY_PREFERRED_BIT = 6;
	localparam int REFC_DEGLITCH_OFF_BIT = 7;
	localparam int RST_REF_BIT = 0;
	localparam int RST_SHARED_BIT = 1;
	localparam int RST_FEEDBACK_BIT = 2;
	localparam int MON_SOURCE_LSB = 0;
	localparam int STATUS_SOURCE_LSB = 4;

	// Encodings.
	localparam logic [2:0] PUMP_HIGH_Z = 3'h0;
	localparam logic [2:0] PUMP_FORCE_UP = 3'h1;
	localparam logic [2:0] PUMP_FORCE_DOWN = 3'h2;
	localparam logic [2:0] PUMP_NORMAL = 3'h3;
	localparam logic [1:0] LOOP_POWER_ON = 2'h0;
	localparam logic [3:0] PIN_SRC_PRIMARY_INVALID = 4'h7;
	localparam logic [3:0] PIN_SRC_SECONDARY_INVALID = 4'h8;
	localparam logic [7:0] UPDATE_VALUE = 8'h01;
	localparam logic [13:0] RDIV_MIN_RATIO = 14'h0001;

	// Timing: a reference is invalid after this long with no rising edge.
	localparam int CLK_PERIOD_NS = 10;
	localparam int REF_TIMEOUT_NS = 2000;
	localparam int REF_TIMEOUT_CYCLES = (REF_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_W = 8;

	// Reset values of the configuration.
	localparam logic [7:0] RESET_BYTE = 8'h00;

	typedef struct packed {
		logic [7:0] loop_control;
		logic [13:0] ref_divider;
		logic [1:0] pulse_width;
		logic [1:0] sync_enable;
		logic [7:0] monitor_pin_select;
		logic [7:0] reference_control;
		logic [2:0] pump_current;
		logic [2:0] divider_reset;
		logic use_status_pin;
	} plm_cfg_t;

	typedef struct packed {
		logic up;
		logic down;
		logic drive_en;
	} plm_pump_t;

	typedef struct packed {
		logic differential_on;
		logic primary_on;
		logic secondary_on;
	} plm_buffers_t;

endpackage

//--- design/plm_pll_ref_ctrl.sv
`timescale 1ns/100ps
module plm_pll_ref_ctrl (
	// Clock, reset and enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Reference pins and feedback
	input wire logic primary_reference,
	input wire logic secondary_reference,
	input wire logic feedback_clock,
	input wire logic reference_select_pin,
	input wire logic align_n_pin,
	// Loop outputs
	output plm_pkg::plm_pump_t charge_pump,
	output logic [2:0] pump_current_code,
	output logic [1:0] pulse_width_code,
	output plm_pkg::plm_buffers_t buffers,
	output logic feedback_counter_reset,
	output logic reference_monitor_pin,
	output logic status_pin
);
	import plm_pkg::*;

	typedef enum logic [1:0] {
		PD_IDLE = 2'b00,
		PD_BOTH = 2'b01,
		PD_CLEAR = 2'b10
	} plm_pd_state_t;

	plm_cfg_t shadow;
	plm_cfg_t active;
	logic [4:0] pins_s;
	logic [4:0] pins_d;
	logic addr_valid;
	logic addr_write;
	logic [11:0] addr_index;
	logic [IDLE_W-1:0] idle_cnt [2];
	logic [1:0] ref_valid;
	logic active_secondary;
	logic deglitch_hold;
	logic want_secondary;
	logic divided_pulse;
	logic divider_hold;
	logic loop_down;
	logic diff_mode;
	logic trigger;
	logic ref_edge;
	logic pd_up;
	logic pd_down;
	logic [1:0] pd_count;
	plm_pd_state_t pd_state;
	logic [2:0] pump_mode;

	function automatic logic rise(input logic [4:0] cur, input logic [4:0] prev, input int bit_n);
		rise = cur[bit_n] & ~prev[bit_n];
	endfunction

	function automatic logic pin_source(input logic [3:0] code, input logic [1:0] valid);
		case (code)
			PIN_SRC_PRIMARY_INVALID: pin_source = ~valid[0];
			PIN_SRC_SECONDARY_INVALID: pin_source = ~valid[1];
			default: pin_source = 1'b0;
		endcase
	endfunction

	plm_sync #(.WIDTH(5)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.async_in({align_n_pin, reference_select_pin, feedback_clock, secondary_reference,
			primary_reference}),
		.sync_out(pins_s)
	);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pins_d <= 5'h1f;
		else if (ce)
			pins_d <= pins_s;
	end

	// Bus address phase is registered; the slave never inserts wait states.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			addr_valid <= 1'b0;
			addr_write <= 1'b0;
			addr_index <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else if (ce)
		begin
			addr_valid <= hsel & htrans[1] & hready;
			addr_write <= hwrite;
			addr_index <= haddr[13:2];
		end
	end

	// Reads return the written value, which may not yet be active.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= '0;
		else if (ce && hsel && htrans[1] && hready && !hwrite)
		begin
			case (haddr[13:2])
				IDX_LOOP_CONTROL: hrdata <= {24'h00_0000, shadow.loop_control};
				IDX_REF_DIVIDER_LOW: hrdata <= {24'h00_0000, shadow.ref_divider[7:0]};
				IDX_REF_DIVIDER_HIGH: hrdata <= {26'h000_0000, shadow.ref_divider[13:8]};
				IDX_DETECTOR_PULSE_CONTROL: hrdata <= {30'h0000_0000, shadow.pulse_width};
				IDX_SYNC_CONTROL: hrdata <= {24'h00_0000, shadow.sync_enable, 6'h00};
				IDX_MONITOR_PIN_SELECT: hrdata <= {24'h00_0000, shadow.monitor_pin_select};
				IDX_REFERENCE_CONTROL: hrdata <= {24'h00_0000, shadow.reference_control};
				IDX_PUMP_CURRENT: hrdata <= {29'h0000_0000, shadow.pump_current};
				IDX_DIVIDER_RESET: hrdata <= {29'h0000_0000, shadow.divider_reset};
				IDX_SWITCH_OPTIONS: hrdata <= {31'h0000_0000, shadow.use_status_pin};
				IDX_STATUS: hrdata <= {27'h000_0000, deglitch_hold, ref_valid, active_secondary,
					reference_monitor_pin};
				default: hrdata <= '0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			shadow <= '0;
		else if (ce && addr_valid && addr_write)
		begin
			case (addr_index)
				IDX_LOOP_CONTROL: shadow.loop_control <= hwdata[7:0];
				IDX_REF_DIVIDER_LOW: shadow.ref_divider[7:0] <= hwdata[7:0];
				IDX_REF_DIVIDER_HIGH: shadow.ref_divider[13:8] <= hwdata[5:0];
				IDX_DETECTOR_PULSE_CONTROL: shadow.pulse_width <= hwdata[1:0];
				IDX_SYNC_CONTROL: shadow.sync_enable <= hwdata[SYNC_ENABLE_LSB +: 2];
				IDX_MONITOR_PIN_SELECT: shadow.monitor_pin_select <= hwdata[7:0];
				IDX_REFERENCE_CONTROL: shadow.reference_control <= hwdata[7:0];
				IDX_PUMP_CURRENT: shadow.pump_current <= hwdata[2:0];
				IDX_DIVIDER_RESET: shadow.divider_reset <= hwdata[2:0];
				IDX_SWITCH_OPTIONS: shadow.use_status_pin <= hwdata[0];
				default: shadow <= shadow;
			endcase
		end
	end

	// Settings reach the loop only on the update strobe, so a half-written
	// divider value never runs.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			active <= '0;
		else if (ce && addr_valid && addr_write && addr_index == IDX_UPDATE &&
			hwdata[7:0] == UPDATE_VALUE)
			active <= shadow;
	end

	assign loop_down = active.loop_control[LOOP_POWER_LSB +: 2] != LOOP_POWER_ON;
	assign diff_mode = active.reference_control[REFC_DIFF_BIT];
	assign pump_mode = active.loop_control[LOOP_PUMP_MODE_LSB +: 3];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			buffers <= '0;
		else if (ce)
		begin
			buffers.differential_on <= ~loop_down & diff_mode;
			buffers.primary_on <= ~loop_down & ~diff_mode &
				active.reference_control[REFC_PRIMARY_ON_BIT];
			buffers.secondary_on <= ~loop_down & ~diff_mode &
				active.reference_control[REFC_SECONDARY_ON_BIT];
		end
	end

	// A reference is valid while rising edges keep arriving on its pin, whether or not its buffer is powered.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < 2; i++)
				idle_cnt[i] <= '0;
			ref_valid <= 2'b00;
		end
		else if (ce)
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (rise(pins_s, pins_d, i))
				begin
					idle_cnt[i] <= '0;
					ref_valid[i] <= 1'b1;
				end
				else if (idle_cnt[i] >= IDLE_W'(REF_TIMEOUT_CYCLES))
					ref_valid[i] <= 1'b0;
				else
					idle_cnt[i] <= idle_cnt[i] + 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			reference_monitor_pin <= 1'b0;
			status_pin <= 1'b0;
		end
		else if (ce)
		begin
			reference_monitor_pin <= pin_source(active.monitor_pin_select[MON_SOURCE_LSB +: 4],
				ref_valid);
			status_pin <= pin_source(active.monitor_pin_select[STATUS_SOURCE_LSB +: 4],
				ref_valid);
		end
	end

	assign trigger = active.use_status_pin ? status_pin : reference_monitor_pin;

	always_comb
	begin
		if (diff_mode)
			want_secondary = 1'b0;
		else if (active.reference_control[REFC_AUTO_BIT])
			want_secondary = active.reference_control[REFC_SECONDARY_PREFERRED_BIT] ^
				trigger;
		else if (active.reference_control[REFC_PIN_SELECT_BIT])
			want_secondary = pins_s[3];
		else
			want_secondary = active.reference_control[REFC_MANUAL_SECONDARY_BIT];
	end

	// After a switch the first edge of the new reference is swallowed; with
	// no clock on the target the hold never clears, which is why the target
	// must be running or deglitching turned off.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			active_secondary <= 1'b0;
			deglitch_hold <= 1'b0;
		end
		else if (ce)
		begin
			if (want_secondary != active_secondary)
			begin
				active_secondary <= want_secondary;
				deglitch_hold <= ~active.reference_control[REFC_DEGLITCH_OFF_BIT];
			end
			else if (rise(pins_s, pins_d, active_secondary ? 1 : 0))
				deglitch_hold <= 1'b0;
		end
	end

	assign ref_edge = ~deglitch_hold & (active_secondary ?
		(rise(pins_s, pins_d, 1) & buffers.secondary_on) :
		(rise(pins_s, pins_d, 0) & (buffers.primary_on | buffers.differential_on)));

	assign divider_hold = active.divider_reset[RST_REF_BIT] |
		active.divider_reset[RST_SHARED_BIT] |
		((active.sync_enable != 2'b00) & ~pins_s[4]);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			feedback_counter_reset <= 1'b0;
		else if (ce)
			feedback_counter_reset <= active.divider_reset[RST_FEEDBACK_BIT] |
				active.divider_reset[RST_SHARED_BIT] |
				((active.sync_enable != 2'b00) & ~pins_s[4]);
	end

	plm_ref_divider u_rdiv (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.hold(divider_hold),
		.terminal(active.ref_divider),
		.edge_in(ref_edge),
		.pulse(divided_pulse)
	);

	// Detector: both outputs overlap for the dead-zone width before clearing.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pd_state <= PD_IDLE;
			pd_up <= 1'b0;
			pd_down <= 1'b0;
			pd_count <= '0;
		end
		else if (ce)
		begin
			case (pd_state)
				PD_IDLE:
				begin
					pd_up <= pd_up | divided_pulse;
					pd_down <= pd_down | rise(pins_s, pins_d, 2);
					pd_count <= '0;
					if ((pd_up | divided_pulse) & (pd_down | rise(pins_s, pins_d, 2)))
						pd_state <= PD_BOTH;
				end
				PD_BOTH:
				begin
					if (pd_count == active.pulse_width)
						pd_state <= PD_CLEAR;
					else
						pd_count <= pd_count + 2'h1;
				end
				PD_CLEAR:
				begin
					pd_up <= divided_pulse;
					pd_down <= rise(pins_s, pins_d, 2);
					pd_state <= PD_IDLE;
				end
				default: pd_state <= PD_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			charge_pump <= '0;
		else if (ce)
		begin
			if (loop_down)
				charge_pump <= '0;
			else
			begin
				case (pump_mode)
					PUMP_NORMAL:
					begin
						charge_pump.drive_en <= 1'b1;
						charge_pump.up <= active.loop_control[LOOP_POLARITY_BIT] ?
							pd_down : pd_up;
						charge_pump.down <= active.loop_control[LOOP_POLARITY_BIT] ?
							pd_up : pd_down;
					end
					PUMP_FORCE_UP: charge_pump <= '{up: 1'b1, down: 1'b0, drive_en: 1'b1};
					PUMP_FORCE_DOWN: charge_pump <= '{up: 1'b0, down: 1'b1, drive_en: 1'b1};
					default: charge_pump <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pump_current_code <= '0;
			pulse_width_code <= '0;
		end
		else if (ce)
		begin
			pump_current_code <= active.pump_current;
			pulse_width_code <= active.pulse_width;
		end
	end

endmodule

//--- design/plm_ref_divider.sv
`timescale 1ns/100ps
module plm_ref_divider (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Control
	input wire logic hold,
	input wire logic [13:0] terminal,
	// Reference edges in, divided pulse out
	input wire logic edge_in,
	output logic pulse
);
	import plm_pkg::*;

	logic [13:0] count;
	logic [13:0] ratio;

	// A setting of zero behaves as one.
	assign ratio = (terminal < RDIV_MIN_RATIO) ? RDIV_MIN_RATIO : terminal;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			count <= '0;
			pulse <= 1'b0;
		end
		else if (ce)
		begin
			if (hold)
			begin
				count <= '0;
				pulse <= 1'b0;
			end
			else if (edge_in)
			begin
				if (count + 14'h0001 >= ratio)
				begin
					count <= '0;
					pulse <= 1'b1;
				end
				else
				begin
					count <= count + 14'h0001;
					pulse <= 1'b0;
				end
			end
			else
				pulse <= 1'b0;
		end
	end

endmodule

//--- design/plm_sync.sv
`timescale 1ns/100ps
module plm_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	// The first stage feeds only the second one.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else if (ce)
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

//--- tb/plm_pll_ref_ctrl_assertions.sv
`timescale 1ns/100ps
module plm_chk (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// Pins
	input wire logic primary_reference,
	input wire logic secondary_reference,
	input wire plm_pkg::plm_pump_t charge_pump,
	input wire logic [2:0] pump_current_code,
	input wire logic [1:0] pulse_width_code,
	input wire plm_pkg::plm_buffers_t buffers,
	input wire logic reference_monitor_pin,
	input wire logic status_pin
);
	import plm_pkg::*;
	logic upd_ph;
	logic p_q;
	logic s_q;
	logic [2:0] upd_hist;
	logic [7:0] p_idle;
	logic [7:0] s_idle;
	wire logic upd_now = upd_ph && hwdata[7:0] == UPDATE_VALUE;
	wire logic recent = upd_now || |upd_hist;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			upd_ph <= 1'b0;
			upd_hist <= 3'h0;
		end
		else if (ce)
		begin
			upd_ph <= hsel && htrans[1] && hready && hwrite && haddr == {18'h0, IDX_UPDATE, 2'h0};
			upd_hist <= {upd_hist[1:0], upd_now};
		end
	end
	// Idle counters saturate so a long absence never wraps to look fresh.
	always_ff @(posedge hclk)
	begin
		p_q <= primary_reference;
		s_q <= secondary_reference;
		p_idle <= (p_q != primary_reference) ? 8'h00 : p_idle + {7'h0, p_idle != 8'hff};
		s_idle <= (s_q != secondary_reference) ? 8'h00 : s_idle + {7'h0, s_idle != 8'hff};
	end
	sequence s_both;
		charge_pump.up && charge_pump.down;
	endsequence
	property p_cfg_gate;
		$changed({pulse_width_code, pump_current_code}) |-> recent;
	endproperty
	property p_buf_gate;
		$changed(buffers) |-> recent;
	endproperty
	property p_se_off;
		buffers.differential_on |-> !buffers.primary_on && !buffers.secondary_on;
	endproperty
	property p_reset_off;
		$rose(hresetn) |-> buffers == 3'h0;
	endproperty
	property p_reset_pump;
		$rose(hresetn) |-> !charge_pump.drive_en && pump_current_code == 3'h0;
	endproperty
	property p_abl_clear;
		s_both |-> ##[1:6] !(charge_pump.up && charge_pump.down);
	endproperty
	property p_mon_rise;
		$rose(reference_monitor_pin) || $rose(status_pin) |->
			p_idle >= 8'hb4 || s_idle >= 8'hb4 || recent;
	endproperty
	property p_mon_fall;
		$fell(reference_monitor_pin) || $fell(status_pin) |->
			p_idle < 8'h28 || s_idle < 8'h28 || recent;
	endproperty
	a_cfg_gate: assert property (p_cfg_gate) else $error("Codes moved without update.");
	a_buf_gate: assert property (p_buf_gate) else $error("Buffers moved without update.");
	a_se_off: assert property (p_se_off) else $error("Single-ended on in differential.");
	a_reset_off: assert property (p_reset_off) else $error("Buffers on after reset.");
	a_reset_pump: assert property (p_reset_pump) else $error("Pump driven after reset.");
	a_abl_clear: assert property (p_abl_clear) else $error("Up and down overlap too long.");
	a_mon_rise: assert property (p_mon_rise) else $error("Monitor rose with clocks live.");
	a_mon_fall: assert property (p_mon_fall) else $error("Monitor fell while stale.");
endmodule
bind plm_pll_ref_ctrl plm_chk plm_chk_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .primary_reference(primary_reference),
	.secondary_reference(secondary_reference), .charge_pump(charge_pump),
	.pump_current_code(pump_current_code), .pulse_width_code(pulse_width_code),
	.buffers(buffers), .reference_monitor_pin(reference_monitor_pin), .status_pin(status_pin));

//--- tb/plm_ref_src.sv
`timescale 1ns/100ps
module plm_ref_src (
	// Run controls from the bench
	input wire logic run_p,
	input wire logic run_s,
	input wire logic run_f,
	// Clocks into the block
	output logic primary_reference,
	output logic secondary_reference,
	output logic feedback_clock
);
	logic osc = 1'b0;
	// Offset phase keeps the link edges unrelated to hclk.
	initial
	begin
		#3.3;
		forever #80 osc = !osc;
	end
	// A stopped source rests low and never floats, so no false edges appear.
	// The feedback clock is the inverse of the oscillator and also rests low while run_f is low.
	assign primary_reference = osc & run_p;
	assign secondary_reference = osc & run_s;
	assign feedback_clock = !osc & run_f;
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
	import plm_pkg::*;
	localparam logic [11:0] IDX_T [9] = '{12'h010, 12'h011, 12'h012, 12'h017, 12'h019,
		12'h01b, 12'h01c, 12'h020, 12'h021};
	localparam logic [7:0] MSK_T [9] = '{8'hff, 8'hff, 8'h3f, 8'h03, 8'hc0, 8'hff, 8'hff,
		8'h07, 8'h07};
	localparam logic [13:0] R_T [8] = '{14'h0000, 14'h0001, 14'h0003, 14'h0005, 14'h0002,
		14'h0002, 14'h0002, 14'h0002};
	localparam logic [7:0] RST_T [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
	localparam logic [7:0] SYN_T [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00};
	localparam logic ALN_T [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	logic hclk = 1'b0;
	logic hresetn;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic sel_pin = 1'b0;
	logic align_n = 1'b1;
	logic run_p = 1'b1;
	logic hreadyout, hresp, prim, sec, fb, fcr, mon, stat;
	logic [31:0] hrdata, rd;
	logic [2:0] pcc;
	logic [1:0] pwc;
	plm_pump_t cp;
	plm_buffers_t bo;
	logic [15:0] lfsr = 16'd34559;
	int errors = 0;
	int check_count = 0;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
	always #5 hclk = !hclk;
	plm_pll_ref_ctrl plm_pll_ref_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .primary_reference(prim), .secondary_reference(sec),
		.feedback_clock(fb), .reference_select_pin(sel_pin), .align_n_pin(align_n),
		.charge_pump(cp), .pump_current_code(pcc), .pulse_width_code(pwc), .buffers(bo),
		.feedback_counter_reset(fcr), .reference_monitor_pin(mon), .status_pin(stat));
	plm_ref_src plm_ref_src_inst (.run_p(run_p), .run_s(1'b1), .run_f(1'b1),
		.primary_reference(prim), .secondary_reference(sec), .feedback_clock(fb));
	function automatic logic [15:0] next_lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic plm_buffers_t exp_buf(input logic [7:0] lc, input logic [7:0] rc);
		logic on;
		on = lc[1:0] == LOOP_POWER_ON;
		return '{on & rc[0], on & !rc[0] & rc[1], on & !rc[0] & rc[2]};
	endfunction
	task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
		htrans <= 2'h2;
		haddr <= {18'h0, idx, 2'h0};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask
	task automatic upd;
		bus(1'b1, IDX_UPDATE, UPDATE_VALUE);
		repeat (3) @(posedge hclk);
	endtask
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#400_000;
		errors++;
		give_verdict();
	end
	initial
	begin
		logic [7:0] lc, rc;
		logic [1:0] ew;
		logic [2:0] ec;
		logic q;
		int n, e;
		// An edge into reset at time zero clears the registers before the first tick.
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (IDX_T[i])
		begin
			bus(1'b0, IDX_T[i], 8'h00);
			`CHK(rd, 32'h0000_0000)
		end
		`CHK({bo, cp.drive_en}, 4'h0)
		foreach (IDX_T[i])
		begin
			lfsr = next_lfsr(lfsr);
			bus(1'b1, IDX_T[i], lfsr[7:0]);
			bus(1'b0, IDX_T[i], 8'h00);
			`CHK(rd[7:0], lfsr[7:0] & MSK_T[i])
		end
		bus(1'b1, 12'h0ff, 8'h5a);
		bus(1'b0, 12'h0ff, 8'h00);
		`CHK(rd, 32'h0000_0000)
		$display("Test registers done");
		{ew, ec} = 5'h00;
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b1, IDX_DETECTOR_PULSE_CONTROL, 8'(i));
			bus(1'b1, IDX_PUMP_CURRENT, 8'(7 - i));
			bus(1'b1, IDX_UPDATE, 8'h02);
			repeat (3) @(posedge hclk);
			`CHK({pwc, pcc}, {ew, ec})
			upd();
			ew = 2'(i);
			ec = 3'(7 - i);
			`CHK({pwc, pcc}, {ew, ec})
		end
		$display("Test codes done");
		for (int i = 0; i < 12; i++)
		begin
			lfsr = next_lfsr(lfsr);
			lc = {1'b0, 3'(i % 5), 2'h0, lfsr[9], 1'b0};
			rc = (i == 0) ? 8'h07 : lfsr[7:0];
			bus(1'b1, IDX_LOOP_CONTROL, lc);
			bus(1'b1, IDX_REFERENCE_CONTROL, rc);
			upd();
			`CHK(bo, exp_buf(lc, rc))
			if (lc[1:0] == LOOP_POWER_ON)
				`CHK(cp.drive_en, lc[6:4] inside {3'h1, 3'h2, 3'h3})
			if (lc[1:0] == LOOP_POWER_ON && lc[6:4] inside {3'h1, 3'h2})
				`CHK({cp.up, cp.down}, {lc[6:4] == PUMP_FORCE_UP, lc[6:4] == PUMP_FORCE_DOWN})
		end
		$display("Test buffers done");
		bus(1'b1, IDX_LOOP_CONTROL, 8'h30);
		bus(1'b1, IDX_REFERENCE_CONTROL, 8'h02);
		bus(1'b1, IDX_MONITOR_PIN_SELECT, 8'h00);
		bus(1'b1, IDX_SWITCH_OPTIONS, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			align_n <= ALN_T[i];
			bus(1'b1, IDX_REF_DIVIDER_LOW, R_T[i][7:0]);
			bus(1'b1, IDX_REF_DIVIDER_HIGH, {2'h0, R_T[i][13:8]});
			bus(1'b1, IDX_DIVIDER_RESET, RST_T[i]);
			bus(1'b1, IDX_SYNC_CONTROL, SYN_T[i]);
			upd();
			repeat (64) @(posedge hclk);
			n = 0;
			// 768 cycles span 48 reference periods.
			repeat (768)
			begin
				q = cp.up;
				@(posedge hclk);
				if (cp.up === 1'b1 && q === 1'b0)
					n++;
			end
			e = (RST_T[i] != 0 || (SYN_T[i] != 0 && !ALN_T[i])) ? 0 : 48 / (R_T[i] < 2 ? 1 : R_T[i]);
			`CHK(e == 0 ? n == 0 : (n >= e - 1 && n <= e + 1), 1'b1)
			`CHK(fcr, RST_T[i][1] | (SYN_T[i] != 0 && !ALN_T[i]))
			// With the divider held only the feedback side is latched, so the
			// polarity bit alone decides which pump output is driven.
			if (RST_T[i][0])
			begin
				`CHK({cp.up, cp.down}, 2'b01)
				bus(1'b1, IDX_LOOP_CONTROL, 8'hb0);
				upd();
				`CHK({cp.up, cp.down}, 2'b10)
				bus(1'b1, IDX_LOOP_CONTROL, 8'h30);
			end
		end
		$display("Test divider done");
		for (int k = 0; k < 2; k++)
		begin
			bus(1'b1, IDX_MONITOR_PIN_SELECT, k ? 8'h7f : 8'hf7);
			bus(1'b1, IDX_SWITCH_OPTIONS, 8'(k));
			bus(1'b1, IDX_REFERENCE_CONTROL, 8'h26);
			upd();
			run_p <= 1'b0;
			repeat (260) @(posedge hclk);
			bus(1'b0, IDX_STATUS, 8'h00);
			`CHK({mon, stat, rd[1]}, {k == 0, k == 1, 1'b1})
			run_p <= 1'b1;
			repeat (100) @(posedge hclk);
			bus(1'b0, IDX_STATUS, 8'h00);
			`CHK({mon, stat, rd[1]}, 3'h0)
		end
		bus(1'b1, IDX_SWITCH_OPTIONS, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			rc = (i == 0) ? 8'h16 : (i == 3) ? 8'h11 : 8'h0e;
			sel_pin <= (i == 1);
			bus(1'b1, IDX_REFERENCE_CONTROL, rc);
			upd();
			repeat (40) @(posedge hclk);
			bus(1'b0, IDX_STATUS, 8'h00);
			`CHK(rd[1], i < 2)
		end
		$display("Test switchover done");
		give_verdict();
	end
endmodule
